// ==== ssc_pkg.sv ====
// Shared constants and types for the sample sequence and front-end configuration block
package ssc_pkg;
	// Register offsets
	localparam logic [7:0] SSC_SEQ_CFG2_OFS = 8'h04;
	localparam logic [7:0] SSC_AFE_CFG_OFS = 8'h05;
	// Reset values
	localparam logic [7:0] SSC_SEQ_CFG2_RST = 8'h90;
	localparam logic [7:0] SSC_AFE_CFG_RST = 8'h08;
	// Writable bit masks; other bits are reserved
	localparam logic [7:0] SSC_SEQ_CFG2_MASK = 8'hfe;
	localparam logic [7:0] SSC_AFE_CFG_MASK = 8'h4b;
	// Field positions in the sequence register
	localparam int SSC_RPT_MSB = 7;
	localparam int SSC_RPT_LSB = 5;
	localparam int SSC_PAIR_MSB = 4;
	localparam int SSC_PAIR_LSB = 2;
	localparam int SSC_MODE_BIT = 1;
	// Field positions in the front-end register
	localparam int SSC_TRIM_BIT = 6;
	localparam int SSC_AMB_EN_BIT = 3;
	localparam int SSC_GAIN_MSB = 1;
	localparam int SSC_GAIN_LSB = 0;
	// Gain codes and their attenuation as a right shift
	localparam logic [1:0] SSC_GAIN_X1 = 2'h0;
	localparam logic [1:0] SSC_GAIN_DIV4 = 2'h1;
	localparam logic [1:0] SSC_GAIN_DIV16 = 2'h2;
	localparam logic [2:0] SSC_SHIFT_X1 = 3'h0;
	localparam logic [2:0] SSC_SHIFT_DIV4 = 3'h2;
	localparam logic [2:0] SSC_SHIFT_DIV16 = 3'h4;
	localparam logic [2:0] SSC_SHIFT_DIV32 = 3'h5;
	// Sequence configuration as seen by the sequencer
	typedef struct packed {
		logic [2:0] sequence_repeat_count;
		logic [2:0] sample_pair_count;
		logic sampling_mode_select;
	} ssc_seq_cfg_t;
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		SSC_IDLE = 5'h01,
		SSC_AMB = 5'h02,
		SSC_PH_A = 5'h04,
		SSC_PH_B = 5'h08,
		SSC_DONE = 5'h10
	} ssc_state_t;
endpackage

// ==== ssc_sequencer.sv ====
// Sample sequencer: repeated ambient pulse plus A/B pairs with accumulating counter
`timescale 1ns/1ps
module ssc_sequencer #(
	parameter int ACC_W = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Control
	input wire logic i_start,
	input wire ssc_pkg::ssc_seq_cfg_t i_cfg,
	// Sequence phases
	output logic o_busy,
	output logic o_amb_pulse,
	output logic o_phase_a,
	output logic o_phase_b,
	output logic o_integ_clear,
	output logic o_sample_done,
	output logic [ACC_W-1:0] o_accum
);
	// Number of sequence repeats as a power of two
	function automatic logic [7:0] rpt_total(input logic [2:0] code);
		rpt_total = 8'h01 << code;
	endfunction

	ssc_pkg::ssc_state_t state_q, state_d;
	ssc_pkg::ssc_seq_cfg_t cfg_q, cfg_d;
	logic [7:0] rep_q, rep_d;
	logic [2:0] pair_q, pair_d;
	logic [ACC_W-1:0] acc_q, acc_d;
	logic clr_q, clr_d;
	logic busy_q, busy_d;

	// Next state, counters and accumulation
	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		rep_d = rep_q;
		pair_d = pair_q;
		acc_d = acc_q;
		clr_d = 1'b0;
		case (state_q)
			ssc_pkg::SSC_IDLE: begin
				if (i_start) begin
					cfg_d = i_cfg; // Held for the whole sample
					rep_d = 8'h00;
					pair_d = 3'h0;
					acc_d = '0; // Cleared only at sample start
					clr_d = 1'b1;
					state_d = ssc_pkg::SSC_AMB;
				end
			end
			ssc_pkg::SSC_AMB: begin
				state_d = ssc_pkg::SSC_PH_A;
			end
			ssc_pkg::SSC_PH_A: begin
				acc_d = acc_q + ACC_W'(1);
				state_d = ssc_pkg::SSC_PH_B;
			end
			ssc_pkg::SSC_PH_B: begin
				acc_d = acc_q + ACC_W'(1);
				if (pair_q != cfg_q.sample_pair_count) begin
					pair_d = pair_q + 3'h1;
					state_d = ssc_pkg::SSC_PH_A;
				end else if (rep_q != rpt_total(cfg_q.sequence_repeat_count) - 8'h01) begin
					rep_d = rep_q + 8'h01;
					pair_d = 3'h0;
					state_d = ssc_pkg::SSC_AMB;
				end else begin
					state_d = ssc_pkg::SSC_DONE;
				end
			end
			ssc_pkg::SSC_DONE: begin
				state_d = ssc_pkg::SSC_IDLE;
			end
			default: begin
				state_d = ssc_pkg::SSC_IDLE;
			end
		endcase
		// Busy flag registered so the output needs no inverter after the flop
		busy_d = (state_d != ssc_pkg::SSC_IDLE);
	end

	// State registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ssc_pkg::SSC_IDLE;
			cfg_q <= '0;
			rep_q <= 8'h00;
			pair_q <= 3'h0;
			acc_q <= '0;
			clr_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			rep_q <= rep_d;
			pair_q <= pair_d;
			acc_q <= acc_d;
			clr_q <= clr_d;
			busy_q <= busy_d;
		end
	end

	// Phase outputs decoded from one-hot state flops; busy, clear and count from their own flops
	assign o_busy = busy_q;
	assign o_amb_pulse = state_q[1];
	assign o_phase_a = state_q[2];
	assign o_phase_b = state_q[3];
	assign o_sample_done = state_q[4];
	assign o_integ_clear = clr_q;
	assign o_accum = acc_q;
endmodule

// ==== ssc_config.sv ====
// Sequence and front-end configuration registers with sample sequencer
`timescale 1ns/1ps
module ssc_config #(
	parameter int ACC_W = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Register access from the serial interface
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Sample control
	input wire logic i_sample_start,
	// Sequence timing outputs
	output logic o_busy,
	output logic o_ambient_compensation_pulse,
	output logic o_phase_a,
	output logic o_phase_b,
	output logic o_integ_clear,
	output logic o_sample_done,
	output logic [ACC_W-1:0] o_accum,
	// Front-end controls
	output logic o_ambient_comp_enable,
	output logic o_coarse_correction_trim,
	output logic [2:0] o_gain_shift,
	output logic o_sampling_mode_select
);
	// Gain code to attenuation shift
	function automatic logic [2:0] gain_shift(input logic [1:0] code);
		case (code)
			ssc_pkg::SSC_GAIN_X1: gain_shift = ssc_pkg::SSC_SHIFT_X1;
			ssc_pkg::SSC_GAIN_DIV4: gain_shift = ssc_pkg::SSC_SHIFT_DIV4;
			ssc_pkg::SSC_GAIN_DIV16: gain_shift = ssc_pkg::SSC_SHIFT_DIV16;
			default: gain_shift = ssc_pkg::SSC_SHIFT_DIV32;
		endcase
	endfunction

	logic [7:0] seq_q, seq_d;
	logic [7:0] afe_q, afe_d;
	logic [7:0] rdata_q, rdata_d;
	logic amb_en_q, amb_en_d;
	logic trim_q, trim_d;
	logic [2:0] shift_q, shift_d;
	logic mode_q, mode_d;
	ssc_pkg::ssc_seq_cfg_t seq_cfg;

	// Register writes and read mux
	always_comb begin
		seq_d = seq_q;
		afe_d = afe_q;
		if (i_reg_wr && i_reg_addr == ssc_pkg::SSC_SEQ_CFG2_OFS) begin
			seq_d = i_reg_wdata & ssc_pkg::SSC_SEQ_CFG2_MASK;
		end
		if (i_reg_wr && i_reg_addr == ssc_pkg::SSC_AFE_CFG_OFS) begin
			afe_d = i_reg_wdata & ssc_pkg::SSC_AFE_CFG_MASK;
		end
		case (i_reg_addr)
			ssc_pkg::SSC_SEQ_CFG2_OFS: rdata_d = seq_q;
			ssc_pkg::SSC_AFE_CFG_OFS: rdata_d = afe_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// Front-end control decode
	always_comb begin
		amb_en_d = afe_q[ssc_pkg::SSC_AMB_EN_BIT];
		trim_d = afe_q[ssc_pkg::SSC_TRIM_BIT];
		shift_d = gain_shift(afe_q[ssc_pkg::SSC_GAIN_MSB:ssc_pkg::SSC_GAIN_LSB]);
		mode_d = seq_q[ssc_pkg::SSC_MODE_BIT];
	end

	// Register file and decoded control flops
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			seq_q <= ssc_pkg::SSC_SEQ_CFG2_RST;
			afe_q <= ssc_pkg::SSC_AFE_CFG_RST;
			rdata_q <= 8'h00;
			amb_en_q <= 1'b0;
			trim_q <= 1'b0;
			shift_q <= 3'h0;
			mode_q <= 1'b0;
		end else begin
			seq_q <= seq_d;
			afe_q <= afe_d;
			rdata_q <= rdata_d;
			amb_en_q <= amb_en_d;
			trim_q <= trim_d;
			shift_q <= shift_d;
			mode_q <= mode_d;
		end
	end

	// Sequence fields handed to the sequencer
	assign seq_cfg.sequence_repeat_count = seq_q[ssc_pkg::SSC_RPT_MSB:ssc_pkg::SSC_RPT_LSB];
	assign seq_cfg.sample_pair_count = seq_q[ssc_pkg::SSC_PAIR_MSB:ssc_pkg::SSC_PAIR_LSB];
	assign seq_cfg.sampling_mode_select = seq_q[ssc_pkg::SSC_MODE_BIT];

	// Sample sequencer
	ssc_sequencer #(
		.ACC_W(ACC_W)
	) u_seq (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_start(i_sample_start),
		.i_cfg(seq_cfg),
		.o_busy(o_busy),
		.o_amb_pulse(o_ambient_compensation_pulse),
		.o_phase_a(o_phase_a),
		.o_phase_b(o_phase_b),
		.o_integ_clear(o_integ_clear),
		.o_sample_done(o_sample_done),
		.o_accum(o_accum)
	);

	// Outputs straight from flops
	assign o_reg_rdata = rdata_q;
	assign o_ambient_comp_enable = amb_en_q;
	assign o_coarse_correction_trim = trim_q;
	assign o_gain_shift = shift_q;
	assign o_sampling_mode_select = mode_q;
endmodule

// ==== ssc_config_asserts.sv ====
// Checker for the configuration registers and sample sequencer
`timescale 1ns/1ps
module ssc_config_asserts #(
	parameter int ACC_W = 16
) (
	// Watched ports
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_busy,
	input wire logic o_ambient_comp_enable,
	input wire logic o_ambient_compensation_pulse,
	input wire logic o_phase_a,
	input wire logic o_phase_b,
	input wire logic o_integ_clear,
	input wire logic o_sample_done,
	input wire logic [ACC_W-1:0] o_accum,
	input wire logic [2:0] o_gain_shift
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Register read-back and sequence shape
	rsv_zero_a: assert property ($past(i_reg_addr) == 8'h05 |->
		(o_reg_rdata & ~ssc_pkg::SSC_AFE_CFG_MASK) == 8'h00) else $error("reserved bit set");
	unmapped_zero_a: assert property (!($past(i_reg_addr) inside {8'h04, 8'h05}) |->
		o_reg_rdata == 8'h00) else $error("unmapped read not zero");
	amb_first_a: assert property (o_integ_clear |-> o_ambient_compensation_pulse)
		else $error("sample does not open with ambient pulse");
	a_then_b_a: assert property (o_phase_a |=> o_phase_b) else $error("no B after A");
	acc_inc_a: assert property (o_phase_a || o_phase_b |=> o_accum == $past(o_accum) + 1'b1)
		else $error("count did not advance");
	acc_hold_a: assert property (o_ambient_compensation_pulse && !o_integ_clear
		|=> $stable(o_accum)) else $error("count cleared between repeats");
	gain_code_a: assert property (o_gain_shift inside {3'h0, 3'h2, 3'h4, 3'h5})
		else $error("bad gain shift");
	// Read data and decoded controls both reflect the register at the previous edge
	seq_rsv_a: assert property ($past(i_reg_addr) == 8'h04 |->
		o_reg_rdata[0] == 1'b0) else $error("sequence reserved bit set");
	gain_map_a: assert property ($past(i_reg_addr) == 8'h05 |->
		o_gain_shift == (o_reg_rdata[1] ? (o_reg_rdata[0] ? 3'h5 : 3'h4)
		: (o_reg_rdata[0] ? 3'h2 : 3'h0))) else $error("gain shift does not match code");
	amb_map_a: assert property ($past(i_reg_addr) == 8'h05 |->
		o_ambient_comp_enable == o_reg_rdata[3]) else $error("enable does not match bit");
	done_idle_a: assert property (o_sample_done |=> !o_busy)
		else $error("still busy after sample end");
	// Main scenarios
	done_c: cover property (o_sample_done);
	afe_rd_c: cover property (i_reg_addr == 8'h05);
	repeat_c: cover property (o_ambient_compensation_pulse && !o_integ_clear);
endmodule
bind ssc_config ssc_config_asserts #(.ACC_W(ACC_W)) chk_i (.*);

// ==== ssc_config_tb.sv ====
// Testbench for the configuration registers and sample sequencer
`timescale 1ns/1ps
module ssc_config_tb;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_sample_start = 1'b0;
	logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
	logic o_busy, o_ambient_compensation_pulse, o_phase_a, o_phase_b, o_integ_clear;
	logic o_sample_done, o_ambient_comp_enable, o_coarse_correction_trim, o_sampling_mode_select;
	logic [15:0] o_accum;
	logic [2:0] o_gain_shift;
	int failures = 0, compares = 0, cyc = 0;
	ssc_config uut (.*);
	// Clock
	always #5 i_mclk = ~i_mclk;
	task chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %0t: got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_mclk);
		i_reg_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		i_reg_addr = a;
		@(negedge i_mclk);
		chk({8'h00, o_reg_rdata}, {8'h00, e});
	endtask
	task t_reset;
		rd(8'h04, 8'h90);
		rd(8'h05, 8'h08);
		chk({15'h0, o_ambient_comp_enable}, 16'h1);
		chk({13'h0, o_gain_shift}, 16'h0);
		chk({15'h0, o_coarse_correction_trim}, 16'h0);
		chk({15'h0, o_sampling_mode_select}, 16'h0);
	endtask
	task t_regs;
		wr(8'h04, 8'hff);
		rd(8'h04, 8'hfe);
		chk({15'h0, o_sampling_mode_select}, 16'h1);
		wr(8'h05, 8'hbf);
		rd(8'h05, 8'h0b);
		chk({15'h0, o_ambient_comp_enable}, 16'h1);
		chk({15'h0, o_coarse_correction_trim}, 16'h0);
		chk({13'h0, o_gain_shift}, 16'h5);
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h00);
		wr(8'h05, 8'h00);
		rd(8'h05, 8'h00);
		chk({15'h0, o_ambient_comp_enable}, 16'h0);
	endtask
	task t_gain;
		logic [2:0] sh [4];
		sh = '{3'h0, 3'h2, 3'h4, 3'h5};
		for (int i = 0; i < 4; i++) begin
			wr(8'h05, 8'(i));
			rd(8'h05, 8'(i));
			chk({13'h0, o_gain_shift}, {13'h0, sh[i]});
		end
	endtask
	// One sample with repeat code r and pair code p; a second start while busy is ignored
	task run_sample(input int r, input int p);
		int n, a, b, c, z, k, cyc_exp;
		n = 0;
		a = 0;
		b = 0;
		c = 0;
		z = 0;
		k = 0;
		cyc_exp = (1 << r) * (3 + 2 * p);
		wr(8'h04, {3'(r), 3'(p), 2'h0});
		i_sample_start = 1'b1;
		@(negedge i_mclk);
		while (o_sample_done !== 1'b1 && k < 2000) begin
			n += int'(o_ambient_compensation_pulse);
			a += int'(o_phase_a);
			b += int'(o_phase_b);
			c += int'(o_integ_clear);
			z += int'(o_busy);
			k++;
			i_sample_start = (k == 2);
			@(negedge i_mclk);
		end
		chk(16'(k), 16'(cyc_exp));
		chk(16'(n), 16'(1 << r));
		chk(16'(a), 16'((1 << r) * (p + 1)));
		chk(16'(b), 16'((1 << r) * (p + 1)));
		chk(16'(c), 16'h1);
		chk(16'(z), 16'(cyc_exp));
		chk(o_accum, 16'((2 << r) * (p + 1)));
		chk({15'h0, o_busy}, 16'h1);
		chk({15'h0, o_sampling_mode_select}, 16'h0);
		@(negedge i_mclk);
		chk({15'h0, o_busy}, 16'h0);
	endtask
	task t_seq;
		for (int r = 0; r < 8; r++) begin
			run_sample(r, 1);
		end
		run_sample(0, 7);
		run_sample(1, 0);
	endtask
	task report_and_stop;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop;
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(negedge i_mclk);
		i_rst = 1'b0;
		@(negedge i_mclk);
		t_reset;
		t_regs;
		t_gain;
		t_seq;
		report_and_stop;
	end
endmodule
